// File: include/prsc_pkg.sv
`default_nettype none
// =====================================================================
// shared constants and types of the run/stop/restart controller
package prsc_pkg;
	// clock and timing
	localparam int CLK_HZ = 10_000_000;
	localparam int DEBOUNCE_MS = 10;
	localparam int DEB_CYC_DEF = DEBOUNCE_MS * (CLK_HZ / 1000);
	localparam int DEB_W = 17;
	localparam int BLINK_FAST_MS = 125;
	localparam int FAST_CYC_DEF = BLINK_FAST_MS * (CLK_HZ / 1000);
	localparam int FAST_W = 21;
	localparam logic [1:0] SLOW_DIV_LAST = 2'h3; // slow blink is four times slower

	// operator inputs after debouncing
	localparam int DB_SEL = 0; // selector at run
	localparam int DB_OVR = 1; // mode button at overall reset
	localparam int DB_RST = 2; // mode button at reset
	localparam int DB_CRD = 3; // coordinator switch at run
	localparam int DB_N = 4;

	// i/o existence map
	localparam int IO_N = 128;
	localparam int IO_AW = 7;
	localparam int LIST_WORDS = 4;

	// register bus
	localparam int ADDR_W = 6;
	localparam int DATA_W = 32;
	localparam int BE_W = 4;
	localparam int SCAN_W = 24;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h00;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h04;
	localparam logic [ADDR_W-1:0] OFS_SCANMAX = 6'h08;
	localparam logic [ADDR_W-1:0] OFS_LIST0 = 6'h10;
	localparam logic [ADDR_W-1:0] OFS_MAP0 = 6'h20;
	localparam logic [SCAN_W-1:0] SCAN_MAX_RST = 24'h01_86a0;

	// control register bits
	localparam int CTRL_LIST_EN = 0;
	localparam int CTRL_STOP_CMD = 1;
	localparam int CTRL_FORCE = 2;

	// status register bits
	localparam int STS_STATE = 0;
	localparam int STS_PHASE = 2;
	localparam int STS_RUN_LED = 5;
	localparam int STS_STOP_LED = 6;
	localparam int STS_OUT_DIS = 7;
	localparam int STS_WAS_CYC = 8;
	localparam int STS_OTHER_ERR = 9;
	localparam int STS_IO_TMO = 10;
	localparam int STS_ABSENT = 11;
	localparam int STS_SCAN = 12;

	// operating state
	typedef enum logic [1:0] {
		ST_STOP = 2'h0,
		ST_RUN = 2'h1,
		ST_SLOW = 2'h3,
		ST_ORQ = 2'h2
	} prsc_run_t;

	// phase of one program scan
	typedef enum logic [2:0] {
		PH_INPUT = 3'h0,
		PH_EXEC = 3'h1,
		PH_OUTPUT = 3'h3,
		PH_FLAGS = 3'h2,
		PH_RETRIG = 3'h6
	} prsc_phase_t;

	typedef struct packed {
		prsc_run_t state;
		prsc_phase_t phase;
		logic [DB_N-1:0] sync1;
		logic [DB_N-1:0] sync2;
		logic [DB_N-1:0] stable;
		logic [DB_N-1:0] stablePrev;
		logic [DB_N-1:0][DEB_W-1:0] debCnt;
		logic pwrPrev;
		logic togHeld;
		logic armed;
		logic armCold;
		logic wasCyclic;
		logic otherErr;
		logic ctrlListEn;
		logic ctrlForce;
		logic [SCAN_W-1:0] scanMax;
		logic [SCAN_W-1:0] scanCnt;
		logic [LIST_WORDS-1:0][DATA_W-1:0] addrList;
		logic [IO_N-1:0] existMap;
		logic [FAST_W-1:0] blinkCnt;
		logic [1:0] slowDiv;
		logic fastTog;
		logic slowTog;
		logic ack;
		logic [DATA_W-1:0] rdata;
		logic runLed;
		logic stopLed;
		logic outDis;
		logic ioTimeoutLed;
		logic absentLed;
		logic scanLed;
		logic coldPulse;
		logic warmPulse;
		logic erasePulse;
	} prsc_st_t;

	localparam prsc_st_t ST_RESET = '{
		state: ST_STOP,
		phase: PH_INPUT,
		scanMax: SCAN_MAX_RST,
		outDis: 1'b1,
		stopLed: 1'b1,
		default: '0
	};
endpackage
`default_nettype wire

// File: rtl/prsc_ctrl.sv
// How it works
// [R01] in run, scan phases cycle: inputs, program, outputs, flags, supervision retrigger.
// [R02] service requests pause the scan phase, which then continues.
// [R03] system, device or program errors abort cyclic processing.
// [R04] selector run to stop enters stop and asserts output disable.
// [R05] forcing in stop suppresses output disable.
// [R06] power-up at run warm-restarts only if cyclic before and error free.
// [R07] run indicator lit steadily while cyclic.
// [R08] stop indicator steady after clean stop, peer or selector abort, device fault.
// [R09] rapid stop flashing while overall reset pending; restarts refused.
// [R10] slow flashing after own error or stop command; steady after selector stop.
// [R11] operator holds overall-reset button while toggling stop-run-stop to request.
// [R12] repeating the held toggle erases memory, stays stopped, steady indicator.
// [R13] toggle without the button cancels the request, stopped, steady indicator.
// [R14] i/o acknowledge timeout lights its indicator.
// [R15] cold restart builds existence map; absent address interrupts processing.
// [R16] scan time over maximum lights indicator and interrupts processing.
// [R17] output disable at power loss, undervoltage and stop; shown on indicator.
// [R18] cold restart clears data and restarts the program from the start.
// [R19] cold restart: reset button held, selector to run, then coordinator.
// [R20] warm restart from middle position only if previously cyclic; resumes.
// [R21] auto warm restart needs all at run, memory kept, battery good.
// [R22] any processor stopping in multiprocessor mode stops this one too.
// [R23] operator switches are synchronised and debounced before use; multiProc is used without synchronising or debouncing.
//
// Implementation choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

module prsc_ctrl #(
	parameter int DEBOUNCE_CYC = prsc_pkg::DEB_CYC_DEF,
	parameter int FAST_CYC = prsc_pkg::FAST_CYC_DEF
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register bus
	input wire logic [prsc_pkg::ADDR_W-1:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [prsc_pkg::DATA_W-1:0] avsWriteData,
	input wire logic [prsc_pkg::BE_W-1:0] avsByteEnable,
	output logic [prsc_pkg::DATA_W-1:0] avsReadData,
	output logic avsWaitRequest,
	// operator switches
	input wire logic selRun,
	input wire logic modeOverallReset,
	input wire logic modeReset,
	input wire logic coordRun,
	input wire logic multiProc,
	// power and device events
	input wire logic powerGood,
	input wire logic underVoltage,
	input wire logic powerFailError,
	input wire logic batteryFailure,
	input wire logic ioPowerFailure,
	input wire logic memKept,
	input wire logic peerStop,
	// program execution events
	input wire logic ioAckTimeout,
	input wire logic substitutionError,
	input wire logic phaseDone,
	input wire logic serviceReq,
	input wire logic ioRefValid,
	input wire logic [prsc_pkg::IO_AW-1:0] ioRefAddr,
	input wire logic [prsc_pkg::IO_N-1:0] ioPresent,
	// scan control
	output logic [2:0] cyclePhase,
	output logic phaseActive,
	output logic serviceGrant,
	output logic coldRestart,
	output logic warmRestart,
	output logic ramErase,
	output logic cpuStop,
	// indicators and output disable
	output logic outputDisable,
	output logic runLed,
	output logic stopLed,
	output logic outputDisableLed,
	output logic ioTimeoutLed,
	output logic absentAddrLed,
	output logic scanOverrunLed
);
	import prsc_pkg::*;

	prsc_st_t s;
	prsc_st_t n;
	logic busReq;
	logic selRise;
	logic selFall;
	logic coordFall;
	logic devFault;
	logic stopAbort;
	logic absentHit;
	logic scanOver;
	logic stopCmd;
	logic powerLost;

	// merge written bytes into a register
	function automatic logic [DATA_W-1:0] beMerge(input logic [DATA_W-1:0] old,
			input logic [DATA_W-1:0] wd, input logic [BE_W-1:0] be);
		logic [DATA_W-1:0] r;
		r = old;
		for (int b = 0; b < BE_W; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// =================================================================
	// event decode
	assign busReq = avsRead | avsWrite;
	assign selRise = s.stable[DB_SEL] & ~s.stablePrev[DB_SEL];
	assign selFall = ~s.stable[DB_SEL] & s.stablePrev[DB_SEL];
	assign coordFall = multiProc & ~s.stable[DB_CRD] & s.stablePrev[DB_CRD];
	assign powerLost = ~powerGood | powerFailError;
	assign devFault = batteryFailure | ioPowerFailure;
	// stop without own fault: peer, coordinator, selector, device fault
	assign stopAbort = devFault | peerStop | selFall | coordFall; // see [R22]
	assign absentHit = ioRefValid & ~s.existMap[ioRefAddr]; // see [R15]
	assign scanOver = s.scanCnt > s.scanMax; // see [R16]
	assign stopCmd = avsWrite & s.ack & (avsAddress == OFS_CTRL) & avsByteEnable[0]
		& avsWriteData[CTRL_STOP_CMD];

	// =================================================================
	// next state
	always_comb begin
		n = s;
		n.coldPulse = 1'b0;
		n.warmPulse = 1'b0;
		n.erasePulse = 1'b0;
		// two-stage synchroniser and stability counter per switch
		n.sync1 = {coordRun, modeReset, modeOverallReset, selRun};
		n.sync2 = s.sync1;
		n.stablePrev = s.stable;
		for (int i = 0; i < DB_N; i++) begin
			if (s.sync2[i] == s.stable[i]) begin
				n.debCnt[i] = '0;
			end else if (s.debCnt[i] == DEB_W'(DEBOUNCE_CYC - 1)) begin
				n.stable[i] = s.sync2[i]; // see [R23]
				n.debCnt[i] = '0;
			end else begin
				n.debCnt[i] = s.debCnt[i] + 1'b1;
			end
		end
		n.pwrPrev = powerGood;

		// indicator blink timebase
		if (s.blinkCnt == FAST_W'(FAST_CYC - 1)) begin
			n.blinkCnt = '0;
			n.fastTog = ~s.fastTog;
			n.slowDiv = s.slowDiv + 1'b1;
			if (s.slowDiv == SLOW_DIV_LAST) begin
				n.slowTog = ~s.slowTog;
			end
		end else begin
			n.blinkCnt = s.blinkCnt + 1'b1;
		end

		// bus slave: one wait cycle, answer in the second cycle
		n.ack = busReq & ~s.ack;
		if (avsRead & ~s.ack) begin
			n.rdata = '0;
			if (avsAddress == OFS_CTRL) begin
				n.rdata[CTRL_LIST_EN] = s.ctrlListEn;
				n.rdata[CTRL_FORCE] = s.ctrlForce;
			end else if (avsAddress == OFS_STATUS) begin
				n.rdata[STS_STATE +: 2] = s.state;
				n.rdata[STS_PHASE +: 3] = s.phase;
				n.rdata[STS_RUN_LED] = s.runLed;
				n.rdata[STS_STOP_LED] = s.stopLed;
				n.rdata[STS_OUT_DIS] = s.outDis;
				n.rdata[STS_WAS_CYC] = s.wasCyclic;
				n.rdata[STS_OTHER_ERR] = s.otherErr;
				n.rdata[STS_IO_TMO] = s.ioTimeoutLed;
				n.rdata[STS_ABSENT] = s.absentLed;
				n.rdata[STS_SCAN] = s.scanLed;
			end else if (avsAddress == OFS_SCANMAX) begin
				n.rdata[SCAN_W-1:0] = s.scanMax;
			end else if (avsAddress[ADDR_W-1:4] == OFS_LIST0[ADDR_W-1:4]) begin
				n.rdata = s.addrList[avsAddress[3:2]];
			end else if (avsAddress[ADDR_W-1:4] == OFS_MAP0[ADDR_W-1:4]) begin
				n.rdata = s.existMap[avsAddress[3:2]*DATA_W +: DATA_W];
			end
		end
		if (avsWrite & s.ack) begin
			if (avsAddress == OFS_CTRL && avsByteEnable[0]) begin
				n.ctrlListEn = avsWriteData[CTRL_LIST_EN];
				n.ctrlForce = avsWriteData[CTRL_FORCE];
			end else if (avsAddress == OFS_SCANMAX) begin
				n.scanMax = SCAN_W'(beMerge(DATA_W'(s.scanMax), avsWriteData, avsByteEnable));
			end else if (avsAddress[ADDR_W-1:4] == OFS_LIST0[ADDR_W-1:4]) begin
				n.addrList[avsAddress[3:2]] = beMerge(s.addrList[avsAddress[3:2]],
					avsWriteData, avsByteEnable);
			end
		end

		// stopped states: track the selector toggle and button positions
		if (s.state != ST_RUN) begin
			if (selRise) begin
				n.togHeld = s.stable[DB_OVR];
				n.armed = ~s.stable[DB_OVR] & (s.state != ST_ORQ); // see [R09]
				n.armCold = s.stable[DB_RST];
			end
			if (selFall) begin
				n.armed = 1'b0;
			end
		end

		// operating state
		unique case (s.state)
			ST_RUN: begin
				if (serviceReq) begin
					n.phase = s.phase; // see [R02]
				end else begin
					unique case (s.phase)
						PH_INPUT: if (phaseDone) n.phase = PH_EXEC; // see [R01]
						PH_EXEC: if (phaseDone) n.phase = PH_OUTPUT;
						PH_OUTPUT: begin
							if (phaseDone) begin
								n.phase = (multiProc | s.ctrlListEn) ? PH_FLAGS : PH_RETRIG;
							end
						end
						PH_FLAGS: if (phaseDone) n.phase = PH_RETRIG;
						PH_RETRIG: n.phase = PH_INPUT;
						default: n.phase = PH_INPUT;
					endcase
				end
				// scan supervision, restarted once per scan
				n.scanCnt = (s.phase == PH_RETRIG) ? '0 : s.scanCnt + 1'b1; // see [R16]
				if (ioAckTimeout) n.ioTimeoutLed = 1'b1; // see [R14]
				if (absentHit) n.absentLed = 1'b1; // see [R15]
				if (scanOver) n.scanLed = 1'b1; // see [R16]
				if (stopAbort) begin
					n.state = ST_STOP; // see [R04] [R08] [R22]
				end else if (ioAckTimeout | substitutionError | absentHit | scanOver | stopCmd)
						begin
					n.state = ST_SLOW; // see [R03] [R10]
					n.otherErr = 1'b1;
				end
			end
			ST_SLOW: begin
				if (selFall) n.state = ST_STOP; // see [R10]
			end
			ST_ORQ: begin
				if (selFall) begin
					n.state = ST_STOP; // see [R13]
					n.erasePulse = s.togHeld & s.stable[DB_OVR]; // see [R12]
					if (s.togHeld & s.stable[DB_OVR]) begin
						n.otherErr = 1'b0;
						n.ioTimeoutLed = 1'b0;
						n.absentLed = 1'b0;
						n.scanLed = 1'b0;
					end
				end
			end
			ST_STOP: begin
				if (selFall & s.togHeld & s.stable[DB_OVR]) begin
					n.state = ST_ORQ; // see [R11]
				end
			end
		endcase

		// start from a stopped state once selector (and coordinator) are at run
		if (s.state != ST_RUN && s.state != ST_ORQ && s.armed && s.stable[DB_SEL]
				&& (~multiProc | s.stable[DB_CRD])) begin // see [R19]
			n.armed = 1'b0;
			if (s.armCold & (~multiProc | s.ctrlListEn)) begin
				n.state = ST_RUN; // see [R18]
				n.phase = PH_INPUT;
				n.scanCnt = '0;
				n.coldPulse = 1'b1;
				n.otherErr = 1'b0;
				n.ioTimeoutLed = 1'b0;
				n.absentLed = 1'b0;
				n.scanLed = 1'b0;
				n.existMap = (multiProc | s.ctrlListEn) ? s.addrList : ioPresent; // see [R15]
			end else if (~s.armCold & s.wasCyclic) begin
				n.state = ST_RUN; // see [R20]
				n.warmPulse = 1'b1;
			end else begin
				n.state = ST_SLOW; // illegal restart mode
			end
		end

		// power events override the state and arming chosen above
		if (powerLost) begin
			n.state = ST_STOP;
			n.armed = 1'b0;
		end else if (~s.pwrPrev) begin
			n.armed = 1'b0;
			if (s.stable[DB_SEL] & (~multiProc | s.stable[DB_CRD]) & s.wasCyclic
					& ~s.otherErr & memKept & ~batteryFailure) begin
				n.state = ST_RUN; // see [R06] [R21]
				n.warmPulse = 1'b1;
			end else begin
				n.state = ST_STOP;
			end
		end
		if (n.state == ST_RUN) n.wasCyclic = 1'b1;

		// indicators and output disable follow the next state
		n.runLed = (n.state == ST_RUN); // see [R07]
		unique case (n.state)
			ST_RUN: n.stopLed = 1'b0;
			ST_STOP: n.stopLed = 1'b1; // see [R08]
			ST_SLOW: n.stopLed = n.slowTog; // see [R10]
			ST_ORQ: n.stopLed = n.fastTog; // see [R09]
		endcase
		n.outDis = ~powerGood | underVoltage
			| ((n.state != ST_RUN) & ~s.ctrlForce); // see [R05] [R17]
	end

	// =================================================================
	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= ST_RESET;
		end else begin
			s <= n;
		end
	end

	// =================================================================
	// outputs
	assign avsWaitRequest = busReq & ~s.ack;
	assign avsReadData = s.rdata;
	assign cyclePhase = s.phase;
	assign phaseActive = (s.state == ST_RUN) & ~serviceReq;
	assign serviceGrant = (s.state == ST_RUN) & serviceReq;
	assign coldRestart = s.coldPulse;
	assign warmRestart = s.warmPulse;
	assign ramErase = s.erasePulse;
	assign cpuStop = (s.state != ST_RUN); // see [R22]
	assign outputDisable = s.outDis;
	assign outputDisableLed = s.outDis; // see [R17]
	assign runLed = s.runLed;
	assign stopLed = s.stopLed;
	assign ioTimeoutLed = s.ioTimeoutLed;
	assign absentAddrLed = s.absentLed;
	assign scanOverrunLed = s.scanLed;

	// =================================================================
	// assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence heldToggle;
		selFall && s.togHeld && s.stable[DB_OVR];
	endsequence
	sequence liveRun;
		s.state == ST_RUN && !powerLost && $past(powerGood) && !stopAbort;
	endsequence

	a_outdis_stopped: assert property ((s.state != ST_RUN) && !s.ctrlForce // see [R17]
		&& !$past(s.ctrlForce) |-> outputDisable) else $error("outputs not disabled in stop");
	a_outdis_running: assert property (s.state == ST_RUN // see [R05]
		&& $past(powerGood && !underVoltage) |-> !outputDisable)
		else $error("outputs disabled while running");
	a_sel_stops_run: assert property (s.state == ST_RUN && selFall && !powerLost // see [R04]
		|=> s.state == ST_STOP && stopLed) else $error("selector stop not honoured");
	a_own_err_slow: assert property (liveRun and ioAckTimeout // see [R03]
		|=> s.state == ST_SLOW && ioTimeoutLed) else $error("own error did not stop slow");
	a_orq_refuses_run: assert property (s.state == ST_ORQ && !selFall // see [R09]
		|=> s.state != ST_RUN) else $error("restart while overall reset pending");
	a_overall_erase: assert property (s.state == ST_ORQ ##0 heldToggle ##0 !powerLost // see [R12]
		|=> s.state == ST_STOP && ramErase ##1 !ramErase) else $error("overall reset not done");
	a_overall_cancel: assert property (s.state == ST_ORQ && selFall && !s.togHeld // see [R13]
		&& !powerLost |=> s.state == ST_STOP && !ramErase) else $error("cancel not honoured");
	a_absent_addr: assert property (liveRun and absentHit // see [R15]
		|=> absentAddrLed && s.state == ST_SLOW) else $error("absent address missed");
	a_scan_overrun: assert property (liveRun and scanOver // see [R16]
		|=> scanOverrunLed && cpuStop) else $error("scan overrun missed");
	a_debounce_hold: assert property ($changed(s.stable[DB_SEL]) // see [R23]
		|-> $past(s.sync2[DB_SEL], 2) == s.stable[DB_SEL]) else $error("switch not debounced");
	a_bus_one_wait: assert property ($rose(busReq) |-> avsWaitRequest ##1 !avsWaitRequest)
		else $error("bus answer late");
	a_stop_led_steady: assert property (s.state == ST_STOP |-> stopLed) // see [R08]
		else $error("stop indicator not steady");
endmodule // prsc_ctrl

`default_nettype wire

// File: test/prsc_operator_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// operator switches, peer processors and coordinator
module prsc_operator_model (
	// clock
	input wire logic clk,
	// switch and peer levels
	output logic selRun,
	output logic modeOverallReset,
	output logic modeReset,
	output logic coordRun,
	output logic peerStop
);
	// everything at stop, mode button in the middle
	initial begin
		selRun = 1'b0;
		modeOverallReset = 1'b0;
		modeReset = 1'b0;
		coordRun = 1'b0;
		peerStop = 1'b0;
	end

	// a switch is held long enough to pass the debouncer and be acted on
	task automatic settle();
		repeat (12) @(posedge clk);
	endtask

	task automatic setSel(input logic v);
		@(posedge clk);
		selRun <= v;
		settle();
	endtask

	task automatic setBtn(input logic ovr, input logic rs);
		@(posedge clk);
		modeOverallReset <= ovr;
		modeReset <= rs;
		settle();
	endtask

	task automatic setCrd(input logic v);
		@(posedge clk);
		coordRun <= v;
		settle();
	endtask

	// stop-run-stop with the button held at overall reset or not
	task automatic toggle(input logic ovr);
		setBtn(ovr, 1'b0);
		setSel(1'b1);
		setSel(1'b0);
		setBtn(1'b0, 1'b0);
	endtask

	// reset held at selector rise, then coordinator to run when coupled
	task automatic cold(input logic mp);
		setBtn(1'b0, 1'b1);
		setSel(1'b1);
		if (mp) begin
			setCrd(1'b1);
		end
		setBtn(1'b0, 1'b0);
	endtask

	// a peer stops for one cycle
	task automatic peer();
		@(posedge clk);
		peerStop <= 1'b1;
		@(posedge clk);
		peerStop <= 1'b0;
	endtask
endmodule // prsc_operator_model
`default_nettype wire

// File: test/prsc_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// self-checking bench of the run/stop/restart controller
module prsc_ctrl_test;
	import prsc_pkg::*;
	localparam logic [IO_N-1:0] MAP_PAT = 128'h0000_ffff_a5a5_5a5a_1234_5678_ffff_0000;
	localparam logic [2:0] PH_SEQ [4] = '{3'h1, 3'h3, 3'h2, 3'h6};
	localparam logic [1:0] EV_ST [5] = '{2'h0, 2'h0, 2'h0, 2'h3, 2'h3};
	// design inputs, all defined at time zero
	logic clk = 1'b0, rst = 1'b1;
	logic [ADDR_W-1:0] avsAddress = '0;
	logic avsRead = 1'b0, avsWrite = 1'b0;
	logic [DATA_W-1:0] avsWriteData = '0;
	logic [BE_W-1:0] avsByteEnable = 4'hf;
	logic multiProc = 1'b0, powerGood = 1'b1, underVoltage = 1'b0, powerFailError = 1'b0;
	logic batteryFailure = 1'b0, ioPowerFailure = 1'b0, memKept = 1'b1;
	logic ioAckTimeout = 1'b0, substitutionError = 1'b0, phaseDone = 1'b0, serviceReq = 1'b0;
	logic ioRefValid = 1'b0;
	logic [IO_AW-1:0] ioRefAddr = '0;
	logic [IO_N-1:0] ioPresent = MAP_PAT;
	// switch levels and design outputs
	logic selRun, modeOverallReset, modeReset, coordRun, peerStop;
	logic [DATA_W-1:0] avsReadData;
	logic avsWaitRequest, phaseActive, serviceGrant, coldRestart, warmRestart, ramErase, cpuStop;
	logic [2:0] cyclePhase;
	logic outputDisable, runLed, stopLed, outputDisableLed, ioTimeoutLed, absentAddrLed;
	logic scanOverrunLed;
	int errors = 0, totalChecks = 0, nCold = 0, nWarm = 0, nErase = 0;

	prsc_operator_model op (.clk(clk), .selRun(selRun), .modeOverallReset(modeOverallReset),
		.modeReset(modeReset), .coordRun(coordRun), .peerStop(peerStop));

	prsc_ctrl #(.DEBOUNCE_CYC(4), .FAST_CYC(4)) dut (.clk(clk), .rst(rst),
		.avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
		.avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
		.avsWaitRequest(avsWaitRequest), .selRun(selRun), .modeOverallReset(modeOverallReset),
		.modeReset(modeReset), .coordRun(coordRun), .multiProc(multiProc), .powerGood(powerGood),
		.underVoltage(underVoltage), .powerFailError(powerFailError),
		.batteryFailure(batteryFailure), .ioPowerFailure(ioPowerFailure), .memKept(memKept),
		.peerStop(peerStop), .ioAckTimeout(ioAckTimeout), .substitutionError(substitutionError),
		.phaseDone(phaseDone), .serviceReq(serviceReq), .ioRefValid(ioRefValid),
		.ioRefAddr(ioRefAddr), .ioPresent(ioPresent), .cyclePhase(cyclePhase),
		.phaseActive(phaseActive), .serviceGrant(serviceGrant), .coldRestart(coldRestart),
		.warmRestart(warmRestart), .ramErase(ramErase), .cpuStop(cpuStop),
		.outputDisable(outputDisable), .runLed(runLed), .stopLed(stopLed),
		.outputDisableLed(outputDisableLed), .ioTimeoutLed(ioTimeoutLed),
		.absentAddrLed(absentAddrLed), .scanOverrunLed(scanOverrunLed));

	// clock and restart pulse counters
	always #50 clk = ~clk;
	always @(posedge clk) begin
		if (coldRestart === 1'b1) nCold <= nCold + 1;
		if (warmRestart === 1'b1) nWarm <= nWarm + 1;
		if (ramErase === 1'b1) nErase <= nErase + 1;
	end

	// ==========================================
	// shared tasks
	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", totalChecks, errors);
		if (errors == 0 && totalChecks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		totalChecks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// request held until waitrequest is seen low at a rising edge
	task automatic busRd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge clk);
		avsAddress <= a;
		avsRead <= 1'b1;
		do @(posedge clk); while (avsWaitRequest !== 1'b0);
		d = avsReadData;
		avsRead <= 1'b0;
	endtask

	task automatic busWr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		@(posedge clk);
		avsAddress <= a;
		avsWriteData <= v;
		avsWrite <= 1'b1;
		do @(posedge clk); while (avsWaitRequest !== 1'b0);
		avsWrite <= 1'b0;
	endtask

	task automatic waitc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic st(input logic [1:0] e);
		logic [DATA_W-1:0] d;
		busRd(OFS_STATUS, d);
		chk(32'(d[1:0]), 32'(e));
	endtask

	task automatic pulse();
		@(posedge clk);
		phaseDone <= 1'b1;
		@(posedge clk);
		phaseDone <= 1'b0;
		#1;
	endtask

	task automatic ioRef(input logic [IO_AW-1:0] a);
		@(posedge clk);
		ioRefValid <= 1'b1;
		ioRefAddr <= a;
		@(posedge clk);
		ioRefValid <= 1'b0;
		waitc(3);
	endtask

	// selector back to stop, then warm restart from the middle position
	task automatic rec();
		op.setSel(1'b0);
		st(2'h0);
		op.setSel(1'b1);
		st(2'h1);
	endtask

	task automatic pwr(input logic mk);
		@(posedge clk);
		powerGood <= 1'b0;
		powerFailError <= 1'b1;
		memKept <= mk;
		waitc(3);
		chk(32'({outputDisable, outputDisableLed, runLed}), 32'h0000_0006);
		@(posedge clk);
		powerGood <= 1'b1;
		powerFailError <= 1'b0;
		waitc(3);
	endtask

	task automatic evt(input int k);
		if (k == 0) begin
			op.peer();
		end else begin
			@(posedge clk);
			batteryFailure <= (k == 1);
			ioPowerFailure <= (k == 2);
			ioAckTimeout <= (k == 3);
			substitutionError <= (k == 4);
			@(posedge clk);
			{batteryFailure, ioPowerFailure, ioAckTimeout, substitutionError} <= 4'h0;
		end
		waitc(3);
	endtask

	// ==========================================
	// watchdog
	initial begin
		repeat (30000) @(posedge clk);
		errors++;
		report_and_stop();
	end

	// ==========================================
	// test sequence
	initial begin
		logic [DATA_W-1:0] d;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		// idle state and register access
		busRd(OFS_STATUS, d);
		chk(d & 32'h0000_00e3, 32'h0000_00c0);
		busRd(OFS_SCANMAX, d);
		chk(d, 32'(SCAN_MAX_RST));
		// only the enabled byte lane of the limit is written
		@(posedge clk);
		avsByteEnable <= 4'h1;
		busWr(OFS_SCANMAX, 32'h0000_0055);
		busRd(OFS_SCANMAX, d);
		avsByteEnable <= 4'hf;
		chk(d, 32'({SCAN_MAX_RST[SCAN_W-1:8], 8'h55}));
		busWr(6'h3c, 32'hffff_ffff);
		busRd(6'h3c, d);
		chk(d, 32'h0000_0000);
		busWr(OFS_CTRL, 32'h0000_0005);
		busRd(OFS_CTRL, d);
		chk(d, 32'h0000_0005);
		waitc(3);
		chk(32'(outputDisable), 32'h0000_0000);
		busWr(OFS_CTRL, 32'h0000_0000);
		waitc(3);
		chk(32'(outputDisable), 32'h0000_0001);
		// warm restart before any cyclic run is an operator error
		op.setSel(1'b1);
		st(2'h3);
		op.setSel(1'b0);
		st(2'h0);
		// cold restart builds the existence map
		op.cold(1'b0);
		chk(32'(nCold), 32'h0000_0001);
		chk(32'({runLed, outputDisable, cpuStop, cyclePhase}), 32'h0000_0020);
		for (int i = 0; i < LIST_WORDS; i++) begin
			busRd(OFS_MAP0 + ADDR_W'(4 * i), d);
			chk(d, MAP_PAT[32 * i +: 32]);
		end
		// scan phases with flag exchange configured, then a service pause
		busWr(OFS_CTRL, 32'h0000_0001);
		foreach (PH_SEQ[i]) begin
			pulse();
			chk(32'(cyclePhase), 32'(PH_SEQ[i]));
		end
		waitc(1);
		chk(32'(cyclePhase), 32'h0000_0000);
		@(posedge clk);
		serviceReq <= 1'b1;
		pulse();
		chk(32'({serviceGrant, phaseActive, cyclePhase}), 32'h0000_0010);
		@(posedge clk);
		serviceReq <= 1'b0;
		pulse();
		chk(32'(cyclePhase), 32'h0000_0001);
		ioRef(7'h10);
		st(2'h1);
		// power cycle: automatic warm restart, then refused with memory pulled
		pwr(1'b1);
		chk(32'(nWarm), 32'h0000_0001);
		st(2'h1);
		pwr(1'b0);
		st(2'h0);
		memKept <= 1'b1;
		rec();
		// stops by peer and device faults, aborts by own errors
		foreach (EV_ST[k]) begin
			evt(k);
			st(EV_ST[k]);
			chk(32'(outputDisable), 32'h0000_0001);
			rec();
		end
		chk(32'(ioTimeoutLed), 32'h0000_0001);
		@(posedge clk);
		underVoltage <= 1'b1;
		waitc(3);
		chk(32'({outputDisable, outputDisableLed}), 32'h0000_0003);
		@(posedge clk);
		underVoltage <= 1'b0;
		rec();
		ioRef(7'h00);
		chk(32'(absentAddrLed), 32'h0000_0001);
		st(2'h3);
		rec();
		busWr(OFS_CTRL, 32'h0000_0002);
		st(2'h3);
		rec();
		busWr(OFS_SCANMAX, 32'h0000_0014);
		waitc(40);
		chk(32'(scanOverrunLed), 32'h0000_0001);
		st(2'h3);
		busWr(OFS_SCANMAX, 32'(SCAN_MAX_RST));
		op.setSel(1'b0);
		st(2'h0);
		// overall reset: request, refused restart, cancel, request, execute
		op.toggle(1'b1);
		st(2'h2);
		op.setSel(1'b1);
		st(2'h2);
		chk(32'(runLed), 32'h0000_0000);
		op.setSel(1'b0);
		st(2'h0);
		op.toggle(1'b1);
		st(2'h2);
		op.toggle(1'b1);
		busRd(OFS_STATUS, d);
		chk(d & 32'h0000_0043, 32'h0000_0040);
		chk(32'(nErase), 32'h0000_0001);
		chk(32'({stopLed, ioTimeoutLed, absentAddrLed, scanOverrunLed}), 32'h0000_0008);
		op.setSel(1'b1);
		st(2'h1);
		// coupled cold restart, then the coordinator stops everyone
		op.setSel(1'b0);
		busWr(OFS_CTRL, 32'h0000_0001);
		@(posedge clk);
		multiProc <= 1'b1;
		op.cold(1'b1);
		st(2'h1);
		chk(32'(nCold), 32'h0000_0002);
		op.setCrd(1'b0);
		st(2'h0);
		chk(32'(outputDisable), 32'h0000_0001);
		report_and_stop();
	end
endmodule // prsc_ctrl_test
`default_nettype wire
